// file: core/sps_pkg.sv
// Shared constants and state types of the select-synchronised serial port
package sps_pkg;

   // ****************************************************************
   // Bus and register map
   // ****************************************************************
   localparam int         ADDR_W    = 8;
   localparam logic [7:0] OFF_CTRL1 = 8'h00;
   localparam logic [7:0] OFF_CTRL3 = 8'h04;
   localparam logic [7:0] OFF_STAT  = 8'h08;
   localparam logic [7:0] OFF_BUF   = 8'h0c;
   localparam logic [7:0] OFF_ISTAT = 8'h10;
   localparam logic [7:0] OFF_IMASK = 8'h14;
   localparam logic [1:0] RESP_OK   = 2'h0;
   localparam logic [1:0] RESP_ERR  = 2'h2;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int B_WRITE_COLLISION_FLAG = 7;
   localparam int B_OVF  = 6;
   localparam int B_EN   = 5;
   localparam int B_CKP  = 4;
   localparam int B_BUFFER_OVERWRITE_ENABLE = 4;
   localparam int B_SMP  = 7;
   localparam int B_CKE  = 6;
   localparam int B_BF   = 0;
   localparam int I_DONE = 0;
   localparam int I_WRITE_COLLISION_FLAG = 1;
   localparam int I_OVF  = 2;

   // ****************************************************************
   // Modes and timing
   // ****************************************************************
   localparam logic [3:0] MODE_M4     = 4'h0;
   localparam logic [3:0] MODE_M16    = 4'h1;
   localparam logic [3:0] MODE_M64    = 4'h2;
   localparam logic [3:0] MODE_S_SS   = 4'h4;
   localparam logic [3:0] MODE_S_NOSS = 4'h5;
   localparam int         CLK_NS      = 100;
   localparam logic [5:0] HALF_M4     = 6'h01;
   localparam logic [5:0] HALF_M16    = 6'h07;
   localparam logic [5:0] HALF_M64    = 6'h1f;
   localparam logic [4:0] LAST_EDGE   = 5'h0f;
   localparam logic [2:0] LAST_BIT    = 3'h7;

   typedef enum logic [1:0] {M_IDLE = 2'h0, M_RUN = 2'h1} sps_mst_t;

   // ****************************************************************
   // State records
   // ****************************************************************
   typedef struct packed {
      logic              sck_s1, sck_s2, sck_d;
      logic              sdi_s1, sdi_s2;
      logic              ss_s1, ss_s2, ss_d;
      logic              write_collision_flag, ovf, en, clock_idle_polarity;
      logic [3:0]        mode;
      logic              buffer_overwrite_enable, sample_phase_select, cke, bf;
      logic [7:0]        buf_q;
      logic [2:0]        istat, imask;
      sps_mst_t          mst;
      logic [5:0]        div;
      logic [4:0]        edges;
      logic              msck;
      logic              aw_hold;
      logic [ADDR_W-1:0] awaddr_q;
      logic              w_hold;
      logic [7:0]        wdata_q;
      logic              wstrb0;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [7:0]        rdata;
   } sps_top_st_t;

   typedef struct packed {
      logic [7:0] sr;
      logic [2:0] cnt;
      logic       pend;
      logic       rxb;
      logic       done;
      logic [7:0] rx;
   } sps_eng_st_t;

   localparam sps_top_st_t TOP_RST = '0;
   localparam sps_eng_st_t ENG_RST = '0;

endpackage

// file: core/sps_eng_if.sv
// Link between the port control and its shift engine
`timescale 1ns/10ps
`default_nettype none
interface sps_eng_if;
   logic       ce;
   logic       clr;
   logic       load;
   logic [7:0] load_data;
   logic       sample;
   logic       change;
   logic       sdi;
   logic       done;
   logic       busy;
   logic       sdo_bit;
   logic [7:0] rx_byte;
   modport ctl (output ce, clr, load, load_data, sample, change, sdi,
                input done, busy, sdo_bit, rx_byte);
   modport eng (input ce, clr, load, load_data, sample, change, sdi,
                output done, busy, sdo_bit, rx_byte);
endinterface
`default_nettype wire

// file: core/sps_shift_eng.sv
// Eight-bit shift engine with bit counter
`timescale 1ns/10ps
`default_nettype none
module sps_shift_eng (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   // Control side
   sps_eng_if.eng    e
);
   import sps_pkg::*;

   sps_eng_st_t q;
   sps_eng_st_t n;

   assign e.done    = q.done;
   assign e.busy    = (q.cnt != 3'h0) || q.pend;
   assign e.sdo_bit = q.sr[7];
   assign e.rx_byte = q.rx;

   // ****************************************************************
   // Shifting
   // ****************************************************************
   always_comb begin
      n      = q;
      n.done = 1'b0;
      if (e.clr) begin
         n.cnt  = 3'h0;                               // see (RULE4)
         n.pend = 1'b0;
         // Preload while deselected keeps the data for the next frame
         if (e.load) begin
            n.sr = e.load_data;
         end
      end else if (e.load) begin
         n.sr = e.load_data;
      end else if (e.sample) begin
         n.rxb  = e.sdi;
         n.pend = 1'b1;
         n.cnt  = q.cnt + 3'h1;
         if (q.cnt == LAST_BIT) begin
            n.done = 1'b1;                            // see (RULE10)
            n.rx   = {q.sr[6:0], e.sdi};              // see (RULE12)
            // Byte complete: finish the shift so the engine is idle at once
            n.sr   = {q.sr[6:0], e.sdi};
            n.pend = 1'b0;
         end
      end else if (e.change && q.pend) begin
         n.sr   = {q.sr[6:0], q.rxb};                 // see (RULE12)
         n.pend = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         q <= ENG_RST;
      end else if (e.ce) begin
         q <= n;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   a_clear_counter: assert property (e.clr && e.ce |=> !e.busy) // see (RULE4)
      else $error("bit counter not cleared");
   a_done_eighth: assert property ($rose(q.done) |-> $past(q.cnt) == 3'h7) // see (RULE10)
      else $error("byte done before eighth bit");

endmodule
`default_nettype wire

// file: core/sps_spi_slave_sync.sv
// Serial port with select-line framing, sleep handling and register slave
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
// Rules for this block, its master and its software
// (RULE1) Select-framed slave mode only with slave mode field code 0100.
// (RULE2) Select low in that mode: shift both ways and drive data out.
// (RULE3) Select rising: release data output at once, even mid-byte.
// (RULE4) Select high, or port disabled, resets engine and bit counter to zero.
// (RULE5) Each select fall starts a fresh transfer aligned to bit zero.
// (RULE6) Master holds select high when idle, pulls low per transfer.
// (RULE7) Software enables select control for slave with clock-edge bit set.
// (RULE8) Software keeps sample-phase bit clear in slave mode.
// (RULE9) Master mode sleep halts serial clock and freezes transfer; resumes after.
// (RULE10) Slave shifting follows external clock in sleep; byte end flags, wakes.
// (RULE11) Software disables the interrupt to avoid waking on slave bytes.
// (RULE12) MSB first; full byte goes to buffer, sets full and done flags.
// (RULE13) Buffer write during transfer ignored, sets collision flag until cleared.
// (RULE14) Slave without select control ignores select; only disable resets counter.
// (RULE15) Select and done event are in system clock domain before flags.
module sps_spi_slave_sync (
   // Clock, reset, power
   input  wire logic                       ref_clk,
   input  wire logic                       sys_rst,
   input  wire logic                       clk_en,
   input  wire logic                       sleep_req,
   // Register bus write
   input  wire logic [sps_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   // Register bus read
   input  wire logic [sps_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   // Serial pins
   input  wire logic                       sck_in,
   output logic                            sck_out,
   output logic                            sck_oe,
   input  wire logic                       sdi_in,
   output logic                            sdo_out,
   output logic                            sdo_oe,
   input  wire logic                       ss_n_in,
   // Events
   output logic                            irq,
   output logic                            wake
);
   import sps_pkg::*;

   function automatic logic is_master(input logic [3:0] m);
      is_master = (m == MODE_M4) || (m == MODE_M16) || (m == MODE_M64);
   endfunction

   function automatic logic is_slave(input logic [3:0] m);
      is_slave = (m == MODE_S_SS) || (m == MODE_S_NOSS);
   endfunction

   function automatic logic [5:0] half_of(input logic [3:0] m);
      if (m == MODE_M16) begin
         half_of = HALF_M16;
      end else if (m == MODE_M64) begin
         half_of = HALF_M64;
      end else begin
         half_of = HALF_M4;
      end
   endfunction

   function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
      reg_hit = (a == OFF_CTRL1) || (a == OFF_CTRL3) || (a == OFF_STAT)
             || (a == OFF_BUF) || (a == OFF_ISTAT) || (a == OFF_IMASK);
   endfunction

   sps_top_st_t q;
   sps_top_st_t n;
   sps_eng_if   e ();

   logic master_m;
   logic slave_m;
   logic ss_m;
   logic ss_hi;
   logic ss_fall;
   logic slave_go;
   logic m_tog;
   logic m_lead;
   logic m_trail;
   logic s_lead;
   logic s_trail;
   logic lead;
   logic trail;
   logic eng_ce;
   logic busy;
   logic wr_fire;
   logic buf_wr;
   logic rd_fire;
   logic done_ev;

   // ****************************************************************
   // Mode and edge decoding
   // ****************************************************************
   assign master_m = is_master(q.mode);
   assign slave_m  = is_slave(q.mode);
   assign ss_m     = (q.mode == MODE_S_SS);                     // see (RULE1)
   assign ss_hi    = q.ss_s2;                                   // see (RULE15)
   assign ss_fall  = ss_m && q.ss_d && !q.ss_s2;                // see (RULE5)
   assign slave_go = q.en && slave_m && !(ss_m && ss_hi);       // see (RULE14)
   assign m_tog    = (q.mst == M_RUN) && !sleep_req && (q.div == 6'h00);
   assign m_lead   = m_tog && (q.msck == q.clock_idle_polarity);
   assign m_trail  = m_tog && (q.msck != q.clock_idle_polarity);
   assign s_lead   = (q.sck_d == q.clock_idle_polarity) && (q.sck_s2 != q.clock_idle_polarity);
   assign s_trail  = (q.sck_d != q.clock_idle_polarity) && (q.sck_s2 == q.clock_idle_polarity);
   assign lead     = master_m ? m_lead : (slave_go && s_lead);
   assign trail    = master_m ? m_trail : (slave_go && s_trail);
   assign eng_ce   = clk_en && !(sleep_req && master_m);        // see (RULE9)
   assign busy     = e.busy || (q.mst == M_RUN);
   assign done_ev  = e.done && eng_ce;                          // see (RULE15)

   // ****************************************************************
   // Shift engine hookup
   // ****************************************************************
   assign e.ce        = eng_ce;
   assign e.clr       = !q.en || (ss_m && ss_hi) || ss_fall;    // see (RULE4)
   assign e.load      = buf_wr && !busy;
   assign e.load_data = q.wdata_q;
   assign e.sample    = q.cke ? lead : trail;                   // see (RULE2)
   assign e.change    = q.cke ? trail : lead;
   assign e.sdi       = q.sdi_s2;

   sps_shift_eng u_eng (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .e       (e)
   );

   // ****************************************************************
   // Pins and bus handshakes
   // ****************************************************************
   assign sdo_out = e.sdo_bit;
   assign sdo_oe  = q.en && (master_m || (slave_m && !(ss_m && ss_hi))); // see (RULE3)
   assign sck_out = q.msck;
   assign sck_oe  = q.en && master_m;
   assign irq     = |(q.istat & q.imask);
   assign wake    = sleep_req && irq;                           // see (RULE10)

   assign s_axi_awready = !q.aw_hold && !q.bvalid;
   assign s_axi_wready  = !q.w_hold && !q.bvalid;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rresp   = q.rresp;
   assign s_axi_rdata   = {24'h000000, q.rdata};
   assign wr_fire       = q.aw_hold && q.w_hold && !q.bvalid;
   assign buf_wr        = wr_fire && q.wstrb0 && (q.awaddr_q == OFF_BUF);
   assign rd_fire       = s_axi_arvalid && !q.rvalid;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      logic [7:0] rd_v;
      rd_v = 8'h00;
      n    = q;
      // Pin synchronisers
      n.sck_s1 = sck_in;
      n.sck_s2 = q.sck_s1;
      n.sck_d  = q.sck_s2;
      n.sdi_s1 = sdi_in;
      n.sdi_s2 = q.sdi_s1;
      n.ss_s1  = ss_n_in;
      n.ss_s2  = q.ss_s1;
      n.ss_d   = q.ss_s2;
      // Master clock generator
      case (q.mst)
         M_IDLE: begin
            n.msck = q.clock_idle_polarity;
            if (e.load && master_m && q.en) begin
               n.mst   = M_RUN;
               n.div   = half_of(q.mode);
               n.edges = 5'h00;
            end
         end
         M_RUN: begin
            if (!q.en) begin
               n.mst = M_IDLE;
            end else if (m_tog) begin
               n.msck  = ~q.msck;
               n.div   = half_of(q.mode);
               n.edges = q.edges + 5'h01;
               if (q.edges == LAST_EDGE) begin
                  n.mst = M_IDLE;
               end
            end else if (!sleep_req) begin
               n.div = q.div - 6'h01;
            end
         end
         default: begin
            n.mst = M_IDLE;
         end
      endcase
      // Bus write capture
      if (s_axi_awvalid && s_axi_awready) begin
         n.aw_hold  = 1'b1;
         n.awaddr_q = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         n.w_hold  = 1'b1;
         n.wdata_q = s_axi_wdata[7:0];
         n.wstrb0  = s_axi_wstrb[0];
      end
      if (wr_fire) begin
         n.aw_hold = 1'b0;
         n.w_hold  = 1'b0;
         n.bvalid  = 1'b1;
         n.bresp   = reg_hit(q.awaddr_q) ? RESP_OK : RESP_ERR;
         if (q.wstrb0) begin
            if (q.awaddr_q == OFF_CTRL1) begin
               n.write_collision_flag = q.write_collision_flag && q.wdata_q[B_WRITE_COLLISION_FLAG];
               n.ovf  = q.ovf && q.wdata_q[B_OVF];
               n.en   = q.wdata_q[B_EN];
               n.clock_idle_polarity  = q.wdata_q[B_CKP];
               n.mode = q.wdata_q[3:0];
            end else if (q.awaddr_q == OFF_CTRL3) begin
               n.buffer_overwrite_enable = q.wdata_q[B_BUFFER_OVERWRITE_ENABLE];
            end else if (q.awaddr_q == OFF_STAT) begin
               n.sample_phase_select = q.wdata_q[B_SMP];
               n.cke = q.wdata_q[B_CKE];
            end else if (q.awaddr_q == OFF_ISTAT) begin
               n.istat = q.istat & ~q.wdata_q[2:0];
            end else if (q.awaddr_q == OFF_IMASK) begin
               n.imask = q.wdata_q[2:0];
            end
         end
      end
      if (q.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      // Bus read
      if (s_axi_araddr == OFF_CTRL1) begin
         rd_v[B_WRITE_COLLISION_FLAG] = q.write_collision_flag;
         rd_v[B_OVF]  = q.ovf;
         rd_v[B_EN]   = q.en;
         rd_v[B_CKP]  = q.clock_idle_polarity;
         rd_v[3:0]    = q.mode;
      end else if (s_axi_araddr == OFF_CTRL3) begin
         rd_v[B_BUFFER_OVERWRITE_ENABLE] = q.buffer_overwrite_enable;
      end else if (s_axi_araddr == OFF_STAT) begin
         rd_v[B_SMP] = q.sample_phase_select;
         rd_v[B_CKE] = q.cke;
         rd_v[B_BF]  = q.bf;
      end else if (s_axi_araddr == OFF_BUF) begin
         rd_v = q.buf_q;
      end else if (s_axi_araddr == OFF_ISTAT) begin
         rd_v[2:0] = q.istat;
      end else if (s_axi_araddr == OFF_IMASK) begin
         rd_v[2:0] = q.imask;
      end
      if (rd_fire) begin
         n.rvalid = 1'b1;
         n.rdata  = rd_v;
         n.rresp  = reg_hit(s_axi_araddr) ? RESP_OK : RESP_ERR;
         if (s_axi_araddr == OFF_BUF) begin
            n.bf = 1'b0;
         end
      end else if (q.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      // Buffer write and collision
      if (buf_wr) begin
         if (busy) begin
            n.write_collision_flag          = 1'b1;                             // see (RULE13)
            n.istat[I_WRITE_COLLISION_FLAG] = 1'b1;
         end else begin
            n.buf_q = q.wdata_q;
         end
      end
      // Byte completion
      if (done_ev) begin
         n.istat[I_DONE] = 1'b1;                                // see (RULE10)
         if (q.bf && !q.buffer_overwrite_enable) begin
            n.ovf          = 1'b1;
            n.istat[I_OVF] = 1'b1;
         end else begin
            n.buf_q = e.rx_byte;                                // see (RULE12)
            n.bf    = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         q <= TOP_RST;
      end else if (clk_en) begin
         q <= n;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   sequence s_buf_write_busy;
      clk_en && buf_wr && busy && !done_ev;
   endsequence

   sequence s_ss_rise;
      clk_en && q.en && ss_m && !q.ss_s2 ##1 q.ss_s2;
   endsequence

   a_drive_selected: assert property (q.en && ss_m && !q.ss_s2 |-> sdo_oe) // see (RULE2)
      else $error("data output not driven while selected");
   a_float_on_rise: assert property (s_ss_rise |-> !sdo_oe) // see (RULE3)
      else $error("data output still driven after select rose");
   a_select_clears: assert property (clk_en && ss_m && q.ss_s2 |=> !e.busy) // see (RULE4)
      else $error("bit counter running while deselected");
   a_disable_clears: assert property (clk_en && !q.en |=> !e.busy [*2]) // see (RULE4)
      else $error("bit counter running while disabled");
   a_noss_ignore: assert property (q.en && q.mode == MODE_S_NOSS |-> sdo_oe) // see (RULE14)
      else $error("select honoured without select control");
   a_sleep_freeze: assert property (clk_en && sleep_req && q.mst == M_RUN
                                    |=> $stable(q.msck) && $stable(q.div)) // see (RULE9)
      else $error("master clock moved during sleep");
   a_done_buffer: assert property (done_ev && clk_en && !q.bf
                                   |=> q.bf && q.buf_q == $past(e.rx_byte)) // see (RULE12)
      else $error("received byte not moved to buffer");
   a_done_flag: assert property (done_ev && clk_en |=> q.istat[I_DONE]) // see (RULE10)
      else $error("done flag not set after byte");
   a_collision: assert property (s_buf_write_busy |=> q.write_collision_flag && $stable(q.buf_q)) // see (RULE13)
      else $error("collision not flagged or buffer changed");

endmodule
`default_nettype wire

// file: tb/sps_spi_master_model.sv
// Behavioural serial master on the far side of the port
`timescale 1ns/10ps
`default_nettype none
module sps_spi_master_model (
   // Serial pins
   output logic      sck,
   output logic      sdi,
   output logic      ss_n,
   input  wire logic sdo,
   input  wire logic sdo_oe
);
   logic last;
   logic line;
   // A released data line shows the inverse of its last driven level
   always_comb line = sdo_oe ? sdo : ~last;
   always @(sdo or sdo_oe) if (sdo_oe) last = sdo;
   initial begin
      sck  = 1'b0;
      sdi  = 1'b0;
      ss_n = 1'b1;
      last = 1'b0;
   end
   // Send nbits of tx MSB first; cke picks the edge that samples
   task automatic xfer(input logic [7:0] tx, input int nbits, input logic use_ss,
                       input logic cke, output logic [7:0] rx);
      rx = 8'h00;
      #37;
      if (use_ss) ss_n <= 1'b0;
      #400;
      for (int i = 7; i > 7 - nbits; i--) begin
         if (cke) begin
            sdi <= tx[i];
            #400 sck <= 1'b1;
            rx[i] = line;
            #400 sck <= 1'b0;
         end else begin
            sck <= 1'b1;
            sdi <= tx[i];
            #400 sck <= 1'b0;
            rx[i] = line;
            #400;
         end
      end
      #400 ss_n <= 1'b1;
      #800;
   endtask
endmodule
`default_nettype wire

// file: tb/spi_slave_select_sync_sleep_bench.sv
// Self-checking bench of the select-synchronised serial port
`timescale 1ns/10ps
`default_nettype none
module spi_slave_select_sync_sleep_bench;
   import sps_pkg::*;
   logic              ref_clk, sys_rst, clk_en, sleep_req;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0]       wdata, rdata, d;
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp, r;
   logic              awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready;
   logic              sck, sdi, ss_n, sck_out, sck_oe, sdo, sdo_oe, irq, wake, s;
   logic [7:0]        tx, mx, rx;
   int                errors, n_checks, bad;

   sps_spi_slave_sync u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .sleep_req(sleep_req), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sck_in(sck), .sck_out(sck_out), .sck_oe(sck_oe), .sdi_in(sdi), .sdo_out(sdo),
      .sdo_oe(sdo_oe), .ss_n_in(ss_n), .irq(irq), .wake(wake));
   sps_spi_master_model u_mst (.sck(sck), .sdi(sdi), .ss_n(ss_n), .sdo(sdo),
      .sdo_oe(sdo_oe));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // ****************************************************************
   // Bus tasks and checks
   // ****************************************************************
   task automatic results;
      if (errors == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic [31:0] ctl1(input logic wc, input logic [3:0] m);
      ctl1 = {24'h0, wc, 2'h1, 1'h0, m};
   endfunction
   task automatic guard(inout int k);
      k++;
      if (k > 400) begin
         errors++;
         results();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      logic pa, pw, ta, tw, tb;
      int k;
      pa = 1'b1;
      pw = 1'b1;
      k = 0;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         guard(k);
         @(negedge ref_clk);
         ta = pa & awready;
         tw = pw & wready;
         tb = bvalid;
         r = bresp;
         @(posedge ref_clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         pa = pa & ~ta;
         pw = pw & ~tw;
      end while (!tb);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      logic pa, ta, tb;
      int k;
      pa = 1'b1;
      k = 0;
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         guard(k);
         @(negedge ref_clk);
         ta = pa & arready;
         tb = rvalid;
         d = rdata;
         r = rresp;
         @(posedge ref_clk);
         if (ta) arvalid <= 1'b0;
         pa = pa & ~ta;
      end while (!tb);
      rready <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(nm, d, exp);
   endtask
   task automatic wait_irq;
      int k;
      k = 0;
      while (irq !== 1'b1) begin
         guard(k);
         @(negedge ref_clk);
      end
   endtask
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      {sys_rst, clk_en, sleep_req} = 3'h6;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0, 4'hf};
      errors = 0;
      n_checks = 0;
      void'($urandom(58));
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rchk("ctrl1", OFF_CTRL1, 32'h0);
      rd(8'h18);
      chk("unmapped", r, RESP_ERR);
      wr(OFF_STAT, 8'h40);
      chk("bresp", r, RESP_OK);
      wr(OFF_IMASK, 8'h01);
      wr(OFF_CTRL1, {4'h2, MODE_S_SS});
      chk("sdo_oe idle", sdo_oe, 1'b0);
      for (int t = 0; t < 4; t++) begin
         tx = (t == 0) ? 8'h80 : 8'($urandom);
         mx = (t == 0) ? 8'h01 : 8'($urandom);
         wr(OFF_BUF, tx);
         u_mst.xfer(mx, 8, 1'b1, 1'b1, rx);
         wait_irq();
         chk("slave out", rx, tx);
         rchk("stat", OFF_STAT, 32'h41);
         rchk("buf", OFF_BUF, mx);
         rchk("istat", OFF_ISTAT, 32'h1);
         wr(OFF_ISTAT, 8'h01);
         chk("irq clear", irq, 1'b0);
      end
      wr(OFF_BUF, 8'($urandom));
      u_mst.xfer(8'hff, 3, 1'b1, 1'b1, rx);
      chk("sdo_oe abort", sdo_oe, 1'b0);
      rchk("istat abort", OFF_ISTAT, 32'h0);
      tx = 8'($urandom);
      mx = 8'($urandom);
      wr(OFF_BUF, tx);
      u_mst.xfer(mx, 8, 1'b1, 1'b1, rx);
      chk("realign out", rx, tx);
      rchk("realign buf", OFF_BUF, mx);
      wr(OFF_ISTAT, 8'h07);
      wr(OFF_BUF, tx);
      fork
         u_mst.xfer(mx, 8, 1'b1, 1'b1, rx);
         begin
            #2500;
            wr(OFF_BUF, ~tx);
         end
      join
      chk("collide out", rx, tx);
      rchk("write_collision_flag", OFF_CTRL1, ctl1(1'b1, MODE_S_SS));
      rchk("istat write_collision_flag", OFF_ISTAT, 32'h3);
      wr(OFF_CTRL1, {4'h2, MODE_S_SS});
      rchk("write_collision_flag clr", OFF_CTRL1, ctl1(1'b0, MODE_S_SS));
      wr(OFF_ISTAT, 8'h07);
      rd(OFF_BUF);
      sleep_req <= 1'b1;
      u_mst.xfer(8'($urandom), 8, 1'b1, 1'b1, rx);
      wait_irq();
      chk("wake", wake, 1'b1);
      wr(OFF_IMASK, 8'h00);
      chk("no wake", wake, 1'b0);
      wr(OFF_ISTAT, 8'h07);
      wr(OFF_IMASK, 8'h01);
      sleep_req <= 1'b0;
      rd(OFF_BUF);
      wr(OFF_CTRL1, 8'h00);
      wr(OFF_STAT, 8'h00);
      wr(OFF_CTRL1, {4'h2, MODE_S_NOSS});
      mx = 8'($urandom);
      u_mst.xfer(mx, 8, 1'b0, 1'b0, rx);
      wait_irq();
      rchk("noss buf", OFF_BUF, mx);
      wr(OFF_ISTAT, 8'h07);
      wr(OFF_CTRL1, 8'h00);
      wr(OFF_CTRL1, {4'h2, MODE_M4});
      wr(OFF_BUF, 8'($urandom));
      repeat (6) @(posedge ref_clk);
      sleep_req <= 1'b1;
      repeat (2) @(posedge ref_clk);
      s = sck_out;
      bad = 0;
      repeat (20) @(negedge ref_clk) if (sck_out !== s) bad++;
      chk("frozen", bad, 0);
      chk("no done", irq, 1'b0);
      chk("sck_oe", sck_oe, 1'b1);
      @(posedge ref_clk);
      sleep_req <= 1'b0;
      wait_irq();
      rchk("resumed", OFF_ISTAT, 32'h1);
      rchk("master rx", OFF_BUF, {24'h0, {8{sdi}}});
      results();
   end
endmodule
`default_nettype wire
